// >>> hw/interrupt_vector_priority.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "intvec_cfg.svh"
module interrupt_vector_priority
  import intvec_pkg::*;
#(
  parameter int unsigned WDOG_TIMEOUT_CYCLES = `WDOG_TIMEOUT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [17:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        reset_vector_req,
  input  wire logic        software_interrupt,
  input  wire logic        ext_pin_source,
  input  wire logic        timer_a_ch0_source,
  input  wire logic        timer_a_ch1_source,
  input  wire logic        timer_a_overflow_source,
  input  wire logic        timer_b_ch0_source,
  input  wire logic        timer_b_ch1_source,
  input  wire logic        timer_b_overflow_source,
  input  wire logic        serial_error_source,
  input  wire logic        serial_rx_source,
  input  wire logic        serial_tx_source,
  input  wire logic        keypad_source,
  input  wire logic        adc_done_source,
  output logic             irq,
  output logic             vec_valid,
  output logic [15:0]      vec_addr,
  output logic [4:0]       vec_rank,
  output logic             watchdog_restart,
  output logic             watchdog_timeout
);

  // ==========================================
  // State and combinational helpers
  ctl_state_t          state_reg;
  ctl_state_t          state_next;
  logic [`RANK_N-1:0]  rank_req;
  logic                rank_found;
  logic [`RANK_W-1:0]  rank_win;
  logic [15:0]         src_now;
  logic [7:0]          flags_one;
  logic [7:0]          flags_two;
  logic [7:0]          flags_three;
  logic                wr_fire;
  logic                rd_fire;
  logic [15:0]         rd_idx;
  logic [15:0]         status_set;

  // Vector location for each rank; unused ranks never win
  function automatic logic [15:0] rank_vector(input logic [`RANK_W-1:0] r);
    logic [15:0] v;
    v = `VEC_RESET;
    unique case (r)
      5'h00:   v = `VEC_RESET;
      5'h01:   v = `VEC_SWI;
      5'h02:   v = `VEC_EXT;
      5'h04:   v = `VEC_TA_CH0;
      5'h05:   v = `VEC_TA_CH1;
      5'h06:   v = `VEC_TA_OVF;
      5'h07:   v = `VEC_TB_CH0;
      5'h08:   v = `VEC_TB_CH1;
      5'h09:   v = `VEC_TB_OVF;
      5'h0c:   v = `VEC_SER_ERR;
      5'h0d:   v = `VEC_SER_RX;
      5'h0e:   v = `VEC_SER_TX;
      5'h0f:   v = `VEC_KEYPAD;
      5'h10:   v = `VEC_ADC;
      default: v = `VEC_RESET;
    endcase
    return v;
  endfunction

  // Sources gathered by number; bit 0, 2, 9 and 10 stay empty
  always_comb begin
    src_now     = 16'h0000;
    src_now[1]  = state_reg.ext_level;
    src_now[3]  = timer_a_ch0_source;
    src_now[4]  = timer_a_ch1_source;
    src_now[5]  = timer_a_overflow_source;
    src_now[6]  = timer_b_ch0_source;
    src_now[7]  = timer_b_ch1_source;
    src_now[8]  = timer_b_overflow_source;
    src_now[11] = serial_error_source;
    src_now[12] = serial_rx_source;
    src_now[13] = serial_tx_source;
    src_now[14] = keypad_source;
    src_now[15] = adc_done_source;
  end

  // Flag bytes built from the registered pending levels
  always_comb begin
    flags_one              = 8'h00;
    flags_two              = 8'h00;
    flags_three            = 8'h00;
    flags_one[`F1_SRC6]    = state_reg.pend[6];
    flags_one[`F1_SRC5]    = state_reg.pend[5];
    flags_one[`F1_SRC4]    = state_reg.pend[4];
    flags_one[`F1_SRC3]    = state_reg.pend[3];
    flags_one[`F1_SRC1]    = state_reg.pend[1];
    flags_two[`F2_SRC14]   = state_reg.pend[14];
    flags_two[`F2_SRC13]   = state_reg.pend[13];
    flags_two[`F2_SRC12]   = state_reg.pend[12];
    flags_two[`F2_SRC11]   = state_reg.pend[11];
    flags_two[`F2_SRC8]    = state_reg.pend[8];
    flags_two[`F2_SRC7]    = state_reg.pend[7];
    flags_three[`F3_SRC15] = state_reg.pend[15];
  end

  // Rank 0 reset, rank 1 software, rank n+1 for source n
  // Pending is already masked; bit 0 has no source, so it stays out of the ranks
  assign rank_req = {state_reg.pend[15:1], software_interrupt,
                     reset_vector_req};

  fixed_priority_pick #(
    .N     (`RANK_N),
    .IDX_W (`RANK_W)
  ) u_pick (
    .req   (rank_req),
    .found (rank_found),
    .index (rank_win)
  );

  // ==========================================
  // Bus handshake qualifiers
  assign wr_fire    = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  assign rd_fire    = arvalid && state_reg.arready;
  assign rd_idx     = araddr[17:2];
  // Rise taken from the raw sources, not the next state, so no loop forms
  assign status_set = src_now & ~state_reg.pend & `SRC_IMPL_MASK;

  // ==========================================
  // Next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.wdog_kick = 1'b0;
    state_next.wdog_expire = 1'b0;

    // Pin passes three flops; a level counts once the last two agree
    state_next.ext_sync = {state_reg.ext_sync[1:0], ext_pin_source};
    if (state_reg.ext_sync[2] == state_reg.ext_sync[1]) begin
      state_next.ext_level = state_reg.ext_sync[2];
    end
    state_next.pend = src_now & `SRC_IMPL_MASK;

    // Write address and data are taken in either order
    if (awvalid && state_reg.awready) begin
      state_next.awready = 1'b0;
      state_next.aw_got  = 1'b1;
      state_next.wr_idx  = awaddr[17:2];
    end
    if (wvalid && state_reg.wready) begin
      state_next.wready = 1'b0;
      state_next.w_got  = 1'b1;
      state_next.wdata  = wdata;
      state_next.wstrb  = wstrb;
    end

    // Commit the write once both halves are held
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = `RESP_OKAY;
      unique case (state_reg.wr_idx)
        `EVT_MASK_IDX: begin
          if (state_reg.wstrb[0]) begin
            state_next.mask[7:0] = state_reg.wdata[7:0];
          end
          if (state_reg.wstrb[1]) begin
            state_next.mask[15:8] = state_reg.wdata[15:8];
          end
        end
        // Data and strobes are ignored: any write is a service
        `WDOG_SVC_IDX: state_next.wdog_kick = 1'b1;
        default:       state_next.bresp = `RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid  = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready  = 1'b1;
    end

    // Read: answer one cycle after the address is taken
    state_next.status = state_reg.status;
    if (rd_fire) begin
      state_next.arready = 1'b0;
      state_next.rvalid  = 1'b1;
      state_next.rresp   = `RESP_OKAY;
      state_next.rdata   = 32'h0000_0000;
      unique case (rd_idx)
        `FLAGS_ONE_IDX:   state_next.rdata[7:0] = flags_one;
        `FLAGS_TWO_IDX:   state_next.rdata[7:0] = flags_two;
        `FLAGS_THREE_IDX: state_next.rdata[7:0] = flags_three;
        `EVT_STATUS_IDX: begin
          state_next.rdata[15:0] = state_reg.status;
          state_next.status      = 16'h0000;
        end
        `EVT_MASK_IDX:    state_next.rdata[15:0] = state_reg.mask;
        `WDOG_SVC_IDX:    state_next.rdata = 32'h0000_0000;
        default:          state_next.rresp = `RESP_SLVERR;
      endcase
    end
    if (state_reg.rvalid && rready) begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end

    // New requests set sticky bits after any read clear
    state_next.status = state_next.status | status_set;
    state_next.irq    = |(state_next.status & state_next.mask);

    // Watchdog restarts on service, wraps with a pulse on timeout
    if (state_next.wdog_kick) begin
      state_next.wdog_cnt = 32'h0000_0000;
    end else if (state_reg.wdog_cnt == 32'(WDOG_TIMEOUT_CYCLES - 1)) begin
      state_next.wdog_cnt    = 32'h0000_0000;
      state_next.wdog_expire = 1'b1;
    end else begin
      state_next.wdog_cnt = state_reg.wdog_cnt + 32'h0000_0001;
    end

    // Winner registered for the core's vector fetch
    state_next.vec_valid = rank_found;
    state_next.vec_rank  = rank_win;
    state_next.vec_addr  = rank_vector(rank_win);
  end

  // ==========================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready  <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.mask    <= `EVT_MASK_RST;
      state_reg.vec_addr <= `VEC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign awready          = state_reg.awready;
  assign wready           = state_reg.wready;
  assign bvalid           = state_reg.bvalid;
  assign bresp            = state_reg.bresp;
  assign arready          = state_reg.arready;
  assign rvalid           = state_reg.rvalid;
  assign rdata            = state_reg.rdata;
  assign rresp            = state_reg.rresp;
  assign irq              = state_reg.irq;
  assign vec_valid        = state_reg.vec_valid;
  assign vec_addr         = state_reg.vec_addr;
  assign vec_rank         = state_reg.vec_rank;
  assign watchdog_restart = state_reg.wdog_kick;
  assign watchdog_timeout = state_reg.wdog_expire;

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // One-hot pending pattern with no reset or software request
  function automatic logic only_src(input logic [15:0] p, input int n);
    return p == (16'h0001 << n);
  endfunction
  logic core_quiet;
  assign core_quiet = !reset_vector_req && !software_interrupt;

  a_adc_vector: assert property (only_src(state_reg.pend, 15) && core_quiet
    |=> vec_valid && vec_addr == 16'hffde && vec_rank == 5'h10)
    else $error("converter vector wrong");
  a_tx_vector: assert property (only_src(state_reg.pend, 13) && core_quiet
    |=> vec_addr == 16'hffe2) else $error("serial transmit vector wrong");
  a_rx_vector: assert property (only_src(state_reg.pend, 12) && core_quiet
    |=> vec_addr == 16'hffe4) else $error("serial receive vector wrong");
  a_err_vector: assert property (only_src(state_reg.pend, 11) && core_quiet
    |=> vec_addr == 16'hffe6) else $error("serial error vector wrong");
  a_tb_ovf_vector: assert property (only_src(state_reg.pend, 8) && core_quiet
    |=> vec_addr == 16'hffec) else $error("timer b overflow vector wrong");
  a_tb_ch1_vector: assert property (only_src(state_reg.pend, 7) && core_quiet
    |=> vec_addr == 16'hffee) else $error("timer b channel 1 vector wrong");
  a_tb_ch0_vector: assert property (only_src(state_reg.pend, 6) && core_quiet
    |=> vec_addr == 16'hfff0) else $error("timer b channel 0 vector wrong");
  a_ta_ovf_vector: assert property (only_src(state_reg.pend, 5) && core_quiet
    |=> vec_addr == 16'hfff2) else $error("timer a overflow vector wrong");
  a_ta_ch1_vector: assert property (only_src(state_reg.pend, 4) && core_quiet
    |=> vec_addr == 16'hfff4) else $error("timer a channel 1 vector wrong");
  a_ta_ch0_vector: assert property (only_src(state_reg.pend, 3) && core_quiet
    |=> vec_addr == 16'hfff6) else $error("timer a channel 0 vector wrong");
  a_wdog_service: assert property (wr_fire && state_reg.wr_idx == 16'hffff
    |=> watchdog_restart && state_reg.wdog_cnt == 32'h0 ##1 !watchdog_restart)
    else $error("watchdog not restarted");
  a_flag_readout: assert property (rd_fire && rd_idx == 16'hfe05
    |=> rvalid && rdata[7:0] == $past(flags_two) && rdata[31:8] == 24'h0)
    else $error("flag register read wrong");
  a_reset_first: assert property (reset_vector_req
    |=> vec_valid && vec_addr == 16'hfffe && vec_rank == 5'h00)
    else $error("reset vector not first");
  a_swi_second: assert property (!reset_vector_req && software_interrupt
    |=> vec_addr == 16'hfffc) else $error("software vector not second");
  a_low_num_wins: assert property (core_quiet && !state_reg.pend[1] && state_reg.pend[3]
    && state_reg.pend[15] |=> vec_addr == 16'hfff6) else $error("lower number lost");
  a_ext_vector: assert property (only_src(state_reg.pend, 1) && core_quiet
    |=> vec_addr == 16'hfffa) else $error("pin vector wrong");
  a_key_vector: assert property (only_src(state_reg.pend, 14) && core_quiet
    |=> vec_addr == 16'hffe0) else $error("keypad vector wrong");

  // Bus answers and event logic, which the vector checks above do not reach
  a_read_answer: assert property (rd_fire |=> rvalid && !arready)
    else $error("read answer not next cycle");
  a_write_answer: assert property (wr_fire |=> bvalid && !awready && !wready)
    else $error("write answer not next cycle");
  // A level, so it must track the unmasked sticky bits on every cycle
  a_irq_level: assert property (irq == |(state_reg.status & state_reg.mask))
    else $error("interrupt level wrong");
  // Clear and rise in one cycle: the rise must survive
  a_status_set_wins: assert property (rd_fire && rd_idx == 16'hfe0a && (|status_set)
    |=> state_reg.status == $past(status_set)) else $error("status rise lost on clear");

  c_adc_taken:   cover property (vec_valid && vec_rank == 5'h10);
  c_set_wins:    cover property (rd_fire && rd_idx == 16'hfe0a && (|status_set));
  c_swi_preempt: cover property (software_interrupt && state_reg.pend[3] ##1 vec_rank == 5'h01);
  c_wdog_kick:   cover property (watchdog_restart);
  c_irq_cleared: cover property (irq ##1 rvalid ##1 !irq);
endmodule // interrupt_vector_priority

// >>> pkg/intvec_cfg.svh
`ifndef INTVEC_CFG_SVH
`define INTVEC_CFG_SVH
// Notes on behaviour
// - Converter done source 15 vectors at FFDE high, FFDF low; highest used rank.
// - Serial transmit source 13 vectors at FFE2 high, FFE3 low.
// - Serial receive source 12 vectors at FFE4 high, FFE5 low.
// - Serial error source 11 vectors at FFE6/FFE7; sources 9 and 10 have none.
// - Timer B overflow source 8 vectors at FFEC high, FFED low.
// - Timer B channel 1 source 7 vectors at FFEE high, FFEF low.
// - Timer B channel 0 source 6 vectors at FFF0 high, FFF1 low.
// - Timer A overflow source 5 vectors at FFF2 high, FFF3 low.
// - Timer A channel 1 source 4 vectors at FFF4 high, FFF5 low.
// - Timer A channel 0 source 3 vectors at FFF6/FFF7; source 2 has none.
// - Any write to the watchdog service location FFFF restarts the watchdog.
// - Three read-only source flag registers from FE04 show pending requests.

// ==========================================
// Register indices (byte address is index times four)
`define FLAGS_ONE_IDX   16'hfe04
`define FLAGS_TWO_IDX   16'hfe05
`define FLAGS_THREE_IDX 16'hfe06
`define EVT_STATUS_IDX  16'hfe0a
`define EVT_MASK_IDX    16'hfe0b
`define WDOG_SVC_IDX    16'hffff

// ==========================================
// Vector high-byte locations; low byte is the next address
`define VEC_RESET    16'hfffe
`define VEC_SWI      16'hfffc
`define VEC_EXT      16'hfffa
`define VEC_TA_CH0   16'hfff6
`define VEC_TA_CH1   16'hfff4
`define VEC_TA_OVF   16'hfff2
`define VEC_TB_CH0   16'hfff0
`define VEC_TB_CH1   16'hffee
`define VEC_TB_OVF   16'hffec
`define VEC_SER_ERR  16'hffe6
`define VEC_SER_RX   16'hffe4
`define VEC_SER_TX   16'hffe2
`define VEC_KEYPAD   16'hffe0
`define VEC_ADC      16'hffde

// ==========================================
// Flag register bit positions
`define F1_SRC6  7
`define F1_SRC5  6
`define F1_SRC4  5
`define F1_SRC3  4
`define F1_SRC1  2
`define F2_SRC14 7
`define F2_SRC13 6
`define F2_SRC12 5
`define F2_SRC11 4
`define F2_SRC8  1
`define F2_SRC7  0
`define F3_SRC15 0

// ==========================================
// Reset values, masks, bus codes, timing
`define SRC_IMPL_MASK 16'hf9fa
`define EVT_MASK_RST  16'h0000
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`define RANK_W        5
`define RANK_N        17
`define WDOG_CNT_W    32
`define WDOG_TIMEOUT  8176
`endif

// >>> pkg/intvec_pkg.sv
package intvec_pkg;
  // ==========================================
  // Whole state of the controller
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [15:0] wr_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic [15:0] pend;
    logic [15:0] status;
    logic [15:0] mask;
    logic        irq;
    logic [31:0] wdog_cnt;
    logic        wdog_kick;
    logic        wdog_expire;
    logic        vec_valid;
    logic [15:0] vec_addr;
    logic [4:0]  vec_rank;
  } ctl_state_t;
endpackage

// >>> hw/fixed_priority_pick.sv
`timescale 1ns/1ns
// ==========================================
// Lowest set index wins
module fixed_priority_pick #(
  parameter int N     = 17,
  parameter int IDX_W = 5
) (
  input  wire logic [N-1:0]     req,
  output logic                  found,
  output logic [IDX_W-1:0]      index
);
  // Scan downward so the lowest request is the last to land
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end
endmodule // fixed_priority_pick

// >>> test/vector_fetch_core.sv
`timescale 1ns/1ns
// ==========================================
// Core side: issues reset/software requests, latches each fetched vector
module vector_fetch_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        want_reset,
  input  wire logic        want_swi,
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  output logic             reset_vector_req,
  output logic             software_interrupt,
  output logic [15:0]      fetch_addr
);
  // Registered requests, as a core issues them from its own state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector_req   <= 1'b0;
      software_interrupt <= 1'b0;
      fetch_addr         <= 16'h0000;
    end else begin
      reset_vector_req   <= want_reset;
      software_interrupt <= want_swi;
      // Idle vector bus is ignored, so a stale address is never fetched
      if (vec_valid) fetch_addr <= vec_addr;
    end
  end
endmodule // vector_fetch_core

// >>> test/interrupt_vector_priority_tb.sv
`timescale 1ns/1ns
module interrupt_vector_priority_tb;
  // ==========================================
  // Stimulus and observation
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] src = '0;
  logic        want_reset = 1'b0, want_swi = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, vec_valid;
  logic        watchdog_restart, watchdog_timeout, reset_vector_req, software_interrupt;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [15:0] vec_addr, fetch_addr;
  logic [4:0]  vec_rank;
  int          bad_count = 0, check_count = 0, restart_cnt = 0, since = 0, gap = 0;

  typedef struct packed {
    logic [3:0]  num;
    logic [15:0] vec;
    logic [1:0]  sel;
    logic [7:0]  flag;
  } row_t;
  // Source number, vector high byte, flag register offset, flag bit
  row_t rows [12] = '{
    '{4'd1,  16'hfffa, 2'd0, 8'h04},
    '{4'd3,  16'hfff6, 2'd0, 8'h10},
    '{4'd4,  16'hfff4, 2'd0, 8'h20},
    '{4'd5,  16'hfff2, 2'd0, 8'h40},
    '{4'd6,  16'hfff0, 2'd0, 8'h80},
    '{4'd7,  16'hffee, 2'd1, 8'h01},
    '{4'd8,  16'hffec, 2'd1, 8'h02},
    '{4'd11, 16'hffe6, 2'd1, 8'h10},
    '{4'd12, 16'hffe4, 2'd1, 8'h20},
    '{4'd13, 16'hffe2, 2'd1, 8'h40},
    '{4'd14, 16'hffe0, 2'd1, 8'h80},
    '{4'd15, 16'hffde, 2'd2, 8'h01}
  };

  always #5 aclk = ~aclk;

  // ==========================================
  // Design and core model; watchdog shortened to 20 cycles
  interrupt_vector_priority #(.WDOG_TIMEOUT_CYCLES(20)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .reset_vector_req, .software_interrupt, .ext_pin_source(src[1]),
    .timer_a_ch0_source(src[3]), .timer_a_ch1_source(src[4]),
    .timer_a_overflow_source(src[5]), .timer_b_ch0_source(src[6]),
    .timer_b_ch1_source(src[7]), .timer_b_overflow_source(src[8]),
    .serial_error_source(src[11]), .serial_rx_source(src[12]),
    .serial_tx_source(src[13]), .keypad_source(src[14]), .adc_done_source(src[15]),
    .irq, .vec_valid, .vec_addr, .vec_rank, .watchdog_restart, .watchdog_timeout
  );
  vector_fetch_core core (
    .aclk, .aresetn, .want_reset, .want_swi, .vec_valid, .vec_addr,
    .reset_vector_req, .software_interrupt, .fetch_addr
  );

  // Watchdog pulses: count restarts, keep distance from restart to expiry
  always @(posedge aclk) begin
    since <= watchdog_restart ? 0 : since + 1;
    if (watchdog_restart) restart_cnt <= restart_cnt + 1;
    if (watchdog_timeout) gap <= since;
  end

  // ==========================================
  // Helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [15:0] idx, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic axi_read(input logic [15:0] idx, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    settle(3);
    aresetn <= 1'b1;
    settle(1);
    chk("vec_addr", 32'h0000_fffe, 32'(vec_addr));
    chk("idle", 32'h0000_0003, {29'h0, vec_valid, awready, arready});
    // One source at a time: vector, rank and its flag bit alone
    foreach (rows[i]) begin
      // Eight edges cover the pin's synchroniser plus the registered vector
      src <= 16'h0001 << rows[i].num;
      settle(8);
      chk("vec_addr", 32'(rows[i].vec), 32'(vec_addr));
      chk("vec_rank", 32'(rows[i].num) + 32'h1, 32'(vec_rank));
      axi_read(16'hfe04 + 16'(rows[i].sel), rd, rs);
      chk("flags", 32'(rows[i].flag), rd);
      src <= 16'h0000;
      settle(8);
      chk("vec_valid", 32'h0, 32'(vec_valid));
    end
    // Contention: lowest number, then software, then reset wins
    src <= 16'hc000;
    settle(6);
    chk("vec_addr", 32'h0000_ffe0, 32'(vec_addr));
    src <= 16'hf9fa;
    settle(8);
    chk("vec_addr", 32'h0000_fffa, 32'(vec_addr));
    src <= 16'hf9f8;
    settle(8);
    chk("vec_addr", 32'h0000_fff6, 32'(vec_addr));
    want_swi <= 1'b1;
    settle(6);
    chk("vec_addr", 32'h0000_fffc, 32'(vec_addr));
    chk("vec_rank", 32'h1, 32'(vec_rank));
    want_reset <= 1'b1;
    settle(6);
    chk("fetch_addr", 32'h0000_fffe, 32'(fetch_addr));
    chk("vec_rank", 32'h0, 32'(vec_rank));
    src <= 16'h0000;
    want_swi <= 1'b0;
    want_reset <= 1'b0;
    settle(6);
    // Events: clear leftovers, unmask the converter only
    axi_read(16'hfe0a, rd, rs);
    axi_write(16'hfe0b, 32'h0000_8000, 4'hf, rs);
    chk("mask resp", 32'h0, 32'(rs));
    axi_read(16'hfe0b, rd, rs);
    chk("mask", 32'h0000_8000, rd);
    src <= 16'h8000;
    settle(6);
    src <= 16'h0000;
    settle(6);
    chk("irq sticky", 32'h1, 32'(irq));
    axi_read(16'hfe0a, rd, rs);
    chk("status", 32'h0000_8000, rd);
    settle(2);
    chk("irq cleared", 32'h0, 32'(irq));
    // Masked event is recorded but raises nothing
    src <= 16'h0008;
    settle(6);
    src <= 16'h0000;
    settle(6);
    chk("irq masked", 32'h0, 32'(irq));
    axi_read(16'hfe0a, rd, rs);
    chk("status", 32'h0000_0008, rd);
    // Rise in the very cycle of a status read survives the clear
    fork
      axi_read(16'hfe0a, rd, rs);
      begin
        @(posedge aclk);
        src <= 16'h0020;
      end
    join
    chk("status before rise", 32'h0, rd);
    src <= 16'h0000;
    axi_read(16'hfe0a, rd, rs);
    chk("set wins", 32'h0000_0020, rd);
    // Byte strobe touches the low mask byte only
    axi_write(16'hfe0b, 32'hffff_ffff, 4'h1, rs);
    axi_read(16'hfe0b, rd, rs);
    chk("mask strobe", 32'h0000_80ff, rd);
    // Reserved place and read-only flags both refuse
    axi_read(16'hfe07, rd, rs);
    chk("unmapped resp", 32'h2, 32'(rs));
    chk("unmapped data", 32'h0, rd);
    axi_write(16'hfe04, 32'h0000_00ff, 4'hf, rs);
    chk("flags write resp", 32'h2, 32'(rs));
    // Service write with no strobes still restarts the watchdog
    axi_write(16'hffff, 32'h1234_5678, 4'h0, rs);
    chk("service resp", 32'h0, 32'(rs));
    settle(25);
    // Pulse counters update on the edge after each pulse, so read them later
    chk("restarts", 32'h1, 32'(restart_cnt));
    // Twenty cycles from restart to expiry; the distance counter lags by one
    chk("expiry gap", 32'h0000_0013, 32'(gap));
    // Second reset in mid-run with a source active
    src <= 16'h8000;
    aresetn <= 1'b0;
    settle(3);
    aresetn <= 1'b1;
    src <= 16'h0000;
    settle(1);
    chk("reset vec", 32'h0000_fffe, 32'(vec_addr));
    chk("reset out", 32'h0, {30'h0, irq, vec_valid});
    axi_read(16'hfe0b, rd, rs);
    chk("reset mask", 32'h0, rd);
    tally_and_finish();
  end
endmodule // interrupt_vector_priority_tb
